/* shared/bscan_pkg.sv */
// constants and types for the boundary-scan test port
// How it works
// [R1] bypass instruction puts one-bit register between serial input and output
// [R2] sample/preload captures pin values into boundary cells while core runs
// [R3] sample/preload shifts a pattern into cells, ready to drive later
// [R4] extest drives output pins from cells and captures input pins
// [R5] clamp holds pins from cells while bypass bit forms serial path
// [R6] identification instruction shifts the identification code out
// [R7] user code instruction shifts a 32-bit user code out
// [R8] without test interface the four test pins act as user pins
// [R9] programming instructions are accepted over the same test port
// [R10] controller walks sixteen-state machine with mode pin on rising test clock
// [R11] unknown opcodes act as bypass; reset loads identification instruction
package bscan_pkg;
   // ----------------------------------------
   // instruction register
   // ----------------------------------------
   localparam int IR_LEN = 4;
   localparam logic [IR_LEN-1:0] OP_EXTEST = 4'h0;
   localparam logic [IR_LEN-1:0] OP_SAMPLE = 4'h1;
   localparam logic [IR_LEN-1:0] OP_IDCODE = 4'h2;
   localparam logic [IR_LEN-1:0] OP_USERCODE = 4'h3;
   localparam logic [IR_LEN-1:0] OP_CLAMP = 4'h4;
   localparam logic [IR_LEN-1:0] OP_ISP_WRITE = 4'h8;
   localparam logic [IR_LEN-1:0] OP_ISP_READ = 4'h9;
   localparam logic [IR_LEN-1:0] OP_BYPASS = 4'hF;
   localparam logic [IR_LEN-1:0] IR_CAPTURE = 4'h1;
   // ----------------------------------------
   // data register widths
   // ----------------------------------------
   localparam int ID_LEN = 32;
   localparam int UC_LEN = 32;
   // ----------------------------------------
   // controller states
   // ----------------------------------------
   typedef enum logic [3:0] {
      TEST_LOGIC_RESET, RUN_IDLE,
      SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
      SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
   } tap_state_e;
   // ----------------------------------------
   // selected data path
   // ----------------------------------------
   typedef enum logic [2:0] {
      PATH_BYPASS, PATH_BOUNDARY, PATH_IDCODE, PATH_USERCODE, PATH_ISP
   } dr_path_e;
endpackage

/* rtl/bscan_port.sv */
// boundary-scan test access port, sampled on the core clock
`timescale 1ns/1ns
module bscan_port
   import bscan_pkg::*;
#(
   parameter int PINS = 8,
   parameter int ISP_LEN = 16,
   parameter logic [31:0] IDCODE_VALUE = 32'h0000_0001, // arbitrary value
   parameter logic [31:0] USERCODE_VALUE = 32'h0000_0000 // arbitrary value
) (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic JTAG_ENABLE,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   input wire logic TDO_IN,
   output logic TDO_OUT,
   output logic TDO_OE_N,
   output logic USER_TCK,
   output logic USER_TMS,
   output logic USER_TDI,
   output logic USER_TDO,
   input wire logic USER_TDO_DATA,
   input wire logic USER_TDO_OE_N,
   input wire logic [PINS-1:0] CORE_OUT,
   input wire logic [PINS-1:0] PIN_IN,
   output logic [PINS-1:0] PIN_OUT,
   output logic [PINS-1:0] CORE_IN,
   output logic ISP_WRITE,
   output logic [ISP_LEN-1:0] ISP_WDATA,
   input wire logic [ISP_LEN-1:0] ISP_RDATA,
   output logic [IR_LEN-1:0] INSTR
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic [PINS-1:0] pin1_reg;
   logic [PINS-1:0] pin2_reg;
   logic tck_d_reg;
   logic tck_s, tms_s, tdi_s, tdo_in_s;
   logic tck_rise, tck_fall;

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
         tck_d_reg <= 1'b0;
      end else begin
         sync1_reg <= {TDO_IN, TDI, TMS, TCK};
         sync2_reg <= sync1_reg;
         tck_d_reg <= sync2_reg[0];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pin1_reg <= '0;
         pin2_reg <= '0;
      end else begin
         pin1_reg <= PIN_IN;
         pin2_reg <= pin1_reg;
      end
   end

   assign tck_s = sync2_reg[0];
   assign tms_s = sync2_reg[1];
   assign tdi_s = sync2_reg[2];
   assign tdo_in_s = sync2_reg[3];
   assign tck_rise = JTAG_ENABLE && tck_s && !tck_d_reg;
   assign tck_fall = JTAG_ENABLE && !tck_s && tck_d_reg;

   // ----------------------------------------
   // user pin mode
   // ----------------------------------------
   // test pins become user pins when the test interface is off
   assign USER_TCK = JTAG_ENABLE ? 1'b0 : tck_s; // [R8]
   assign USER_TMS = JTAG_ENABLE ? 1'b0 : tms_s; // [R8]
   assign USER_TDI = JTAG_ENABLE ? 1'b0 : tdi_s; // [R8]
   assign USER_TDO = JTAG_ENABLE ? 1'b0 : tdo_in_s; // [R8]
   assign CORE_IN = pin2_reg;

   // ----------------------------------------
   // controller
   // ----------------------------------------
   tap_state_e state_reg, state_next;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         TEST_LOGIC_RESET: state_next = tms_s ? TEST_LOGIC_RESET : RUN_IDLE;
         RUN_IDLE: state_next = tms_s ? SELECT_DR : RUN_IDLE;
         SELECT_DR: state_next = tms_s ? SELECT_IR : CAPTURE_DR;
         CAPTURE_DR: state_next = tms_s ? EXIT1_DR : SHIFT_DR;
         SHIFT_DR: state_next = tms_s ? EXIT1_DR : SHIFT_DR;
         EXIT1_DR: state_next = tms_s ? UPDATE_DR : PAUSE_DR;
         PAUSE_DR: state_next = tms_s ? EXIT2_DR : PAUSE_DR;
         EXIT2_DR: state_next = tms_s ? UPDATE_DR : SHIFT_DR;
         UPDATE_DR: state_next = tms_s ? SELECT_DR : RUN_IDLE;
         SELECT_IR: state_next = tms_s ? TEST_LOGIC_RESET : CAPTURE_IR;
         CAPTURE_IR: state_next = tms_s ? EXIT1_IR : SHIFT_IR;
         SHIFT_IR: state_next = tms_s ? EXIT1_IR : SHIFT_IR;
         EXIT1_IR: state_next = tms_s ? UPDATE_IR : PAUSE_IR;
         PAUSE_IR: state_next = tms_s ? EXIT2_IR : PAUSE_IR;
         EXIT2_IR: state_next = tms_s ? UPDATE_IR : SHIFT_IR;
         UPDATE_IR: state_next = tms_s ? SELECT_DR : RUN_IDLE;
         default: state_next = TEST_LOGIC_RESET;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= TEST_LOGIC_RESET;
      end else if (!JTAG_ENABLE) begin
         state_reg <= TEST_LOGIC_RESET; // [R8]
      end else if (tck_rise) begin
         state_reg <= state_next; // [R10]
      end
   end

   // ----------------------------------------
   // instruction register
   // ----------------------------------------
   logic [IR_LEN-1:0] ir_shift_reg;
   logic [IR_LEN-1:0] ir_reg;
   dr_path_e path;

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ir_shift_reg <= '0;
         ir_reg <= OP_IDCODE;
      end else if (state_reg == TEST_LOGIC_RESET) begin
         ir_reg <= OP_IDCODE; // [R11]
      end else if (tck_rise) begin
         if (state_reg == CAPTURE_IR) begin
            ir_shift_reg <= IR_CAPTURE;
         end else if (state_reg == SHIFT_IR) begin
            ir_shift_reg <= {tdi_s, ir_shift_reg[IR_LEN-1:1]}; // [R10]
         end else if (state_reg == UPDATE_IR) begin
            ir_reg <= ir_shift_reg;
         end
      end
   end

   assign INSTR = ir_reg;

   always_comb begin
      case (ir_reg)
         OP_EXTEST: path = PATH_BOUNDARY; // [R4]
         OP_SAMPLE: path = PATH_BOUNDARY; // [R2]
         OP_IDCODE: path = PATH_IDCODE; // [R6]
         OP_USERCODE: path = PATH_USERCODE; // [R7]
         OP_CLAMP: path = PATH_BYPASS; // [R5]
         OP_ISP_WRITE: path = PATH_ISP; // [R9]
         OP_ISP_READ: path = PATH_ISP; // [R9]
         default: path = PATH_BYPASS; // [R1] [R11]
      endcase
   end

   // ----------------------------------------
   // data registers
   // ----------------------------------------
   logic bypass_reg;
   logic [PINS-1:0] bsr_shift_reg;
   logic [PINS-1:0] bsr_update_reg;
   logic [ID_LEN-1:0] id_shift_reg;
   logic [UC_LEN-1:0] uc_shift_reg;
   logic [ISP_LEN-1:0] isp_shift_reg;
   logic dr_cap, dr_sh, dr_upd;

   assign dr_cap = tck_rise && state_reg == CAPTURE_DR;
   assign dr_sh = tck_rise && state_reg == SHIFT_DR;
   assign dr_upd = tck_rise && state_reg == UPDATE_DR;

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         bypass_reg <= 1'b0;
      end else if (dr_cap && path == PATH_BYPASS) begin
         bypass_reg <= 1'b0;
      end else if (dr_sh && path == PATH_BYPASS) begin
         bypass_reg <= tdi_s; // [R1] [R5]
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         bsr_shift_reg <= '0;
      end else if (dr_cap && path == PATH_BOUNDARY) begin
         bsr_shift_reg <= pin2_reg; // [R2] [R4]
      end else if (dr_sh && path == PATH_BOUNDARY) begin
         bsr_shift_reg <= {tdi_s, bsr_shift_reg[PINS-1:1]}; // [R3]
      end
   end

   // update latch keeps its pattern across clamp and bypass
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         bsr_update_reg <= '0;
      end else if (dr_upd && path == PATH_BOUNDARY) begin
         bsr_update_reg <= bsr_shift_reg; // [R3]
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         id_shift_reg <= '0;
      end else if (dr_cap && path == PATH_IDCODE) begin
         id_shift_reg <= IDCODE_VALUE; // [R6]
      end else if (dr_sh && path == PATH_IDCODE) begin
         id_shift_reg <= {tdi_s, id_shift_reg[ID_LEN-1:1]}; // [R6]
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         uc_shift_reg <= '0;
      end else if (dr_cap && path == PATH_USERCODE) begin
         uc_shift_reg <= USERCODE_VALUE; // [R7]
      end else if (dr_sh && path == PATH_USERCODE) begin
         uc_shift_reg <= {tdi_s, uc_shift_reg[UC_LEN-1:1]}; // [R7]
      end
   end

   // ----------------------------------------
   // programming data path
   // ----------------------------------------
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         isp_shift_reg <= '0;
      end else if (dr_cap && path == PATH_ISP) begin
         isp_shift_reg <= (ir_reg == OP_ISP_READ) ? ISP_RDATA : '0; // [R9]
      end else if (dr_sh && path == PATH_ISP) begin
         isp_shift_reg <= {tdi_s, isp_shift_reg[ISP_LEN-1:1]}; // [R9]
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ISP_WRITE <= 1'b0;
         ISP_WDATA <= '0;
      end else begin
         ISP_WRITE <= dr_upd && ir_reg == OP_ISP_WRITE; // [R9]
         if (dr_upd && ir_reg == OP_ISP_WRITE) begin
            ISP_WDATA <= isp_shift_reg;
         end
      end
   end

   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   logic pins_from_cells;
   assign pins_from_cells = ir_reg == OP_EXTEST || ir_reg == OP_CLAMP; // [R4] [R5]

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         PIN_OUT <= '0;
      end else begin
         PIN_OUT <= pins_from_cells ? bsr_update_reg : CORE_OUT; // [R2] [R4] [R5]
      end
   end

   // ----------------------------------------
   // serial output, changes on falling test clock
   // ----------------------------------------
   logic tdo_reg, tdo_en_reg, tdo_bit;

   always_comb begin
      case (path)
         PATH_BOUNDARY: tdo_bit = bsr_shift_reg[0];
         PATH_IDCODE: tdo_bit = id_shift_reg[0];
         PATH_USERCODE: tdo_bit = uc_shift_reg[0];
         PATH_ISP: tdo_bit = isp_shift_reg[0];
         default: tdo_bit = bypass_reg;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         tdo_reg <= 1'b0;
         tdo_en_reg <= 1'b0;
      end else if (!JTAG_ENABLE) begin
         tdo_en_reg <= 1'b0;
      end else if (tck_fall) begin
         tdo_en_reg <= state_reg == SHIFT_DR || state_reg == SHIFT_IR; // [R10]
         tdo_reg <= (state_reg == SHIFT_IR) ? ir_shift_reg[0] : tdo_bit; // [R10]
      end
   end

   assign TDO_OUT = JTAG_ENABLE ? tdo_reg : USER_TDO_DATA; // [R8]
   assign TDO_OE_N = JTAG_ENABLE ? !tdo_en_reg : USER_TDO_OE_N; // [R8]
endmodule

/* verification/bscan_port_asserts.sv */
// pin-level assertions for the boundary-scan test port
`timescale 1ns/1ns
module bscan_port_asserts
   import bscan_pkg::*;
#(
   parameter int PINS = 8
) (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic JTAG_ENABLE,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDO_OUT,
   input wire logic TDO_OE_N,
   input wire logic USER_TCK,
   input wire logic USER_TMS,
   input wire logic USER_TDI,
   input wire logic USER_TDO,
   input wire logic USER_TDO_DATA,
   input wire logic USER_TDO_OE_N,
   input wire logic [PINS-1:0] CORE_OUT,
   input wire logic [PINS-1:0] PIN_IN,
   input wire logic [PINS-1:0] PIN_OUT,
   input wire logic [PINS-1:0] CORE_IN,
   input wire logic ISP_WRITE,
   input wire logic [IR_LEN-1:0] INSTR
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   user_pins_a: assert property (
      !JTAG_ENABLE |-> TDO_OUT == USER_TDO_DATA && TDO_OE_N == USER_TDO_OE_N)
      else $error("tdo pin not handed to user logic");
   user_sync_a: assert property (
      !JTAG_ENABLE && $past(RESETN, 2) |-> USER_TMS == $past(TMS, 2) && USER_TCK == $past(TCK, 2))
      else $error("user pin copy wrong");
   user_zero_a: assert property (
      JTAG_ENABLE |-> {USER_TCK, USER_TMS, USER_TDI, USER_TDO} == 4'h0)
      else $error("user pins active in test mode");
   core_in_a: assert property (
      $past(RESETN, 2) |-> CORE_IN == $past(PIN_IN, 2))
      else $error("core input copy wrong");
   sample_live_a: assert property (
      $past(INSTR) == OP_SAMPLE |-> PIN_OUT == $past(CORE_OUT))
      else $error("pins not in normal use while sampling");
   clamp_hold_a: assert property (
      $past(INSTR) == OP_CLAMP && $past(INSTR, 2) == OP_CLAMP |-> $stable(PIN_OUT))
      else $error("clamped pins moved");
   isp_pulse_a: assert property (
      ISP_WRITE |-> INSTR == OP_ISP_WRITE ##1 !ISP_WRITE)
      else $error("program write pulse wrong");
   tdo_fall_a: assert property (
      JTAG_ENABLE && $past(JTAG_ENABLE) && !TDO_OE_N && $past(!TDO_OE_N) && $changed(TDO_OUT)
      |-> !$past(TCK) && !$past(TCK, 2))
      else $error("tdo changed away from a test clock fall");
endmodule
bind bscan_port bscan_port_asserts #(.PINS(PINS)) i_bscan_port_asserts (
   .CORE_CLK, .RESETN, .JTAG_ENABLE, .TCK, .TMS, .TDO_OUT, .TDO_OE_N, .USER_TCK, .USER_TMS,
   .USER_TDI, .USER_TDO, .USER_TDO_DATA, .USER_TDO_OE_N, .CORE_OUT, .PIN_IN, .PIN_OUT,
   .CORE_IN, .ISP_WRITE, .INSTR);

/* verification/tap_master.sv */
// serial test controller model driving clock, mode and data pins
`timescale 1ns/1ns
module tap_master (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // one test clock, tdo taken at the rise; clock idles low
   task automatic step(input logic m, input logic d, output logic b);
      tms = m;
      tdi = d;
      #62 tck = 1'b1;
      b = tdo;
      #63 tck = 1'b0;
   endtask
   task automatic tap_reset();
      logic b;
      repeat (5) step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
   endtask
   // idle to shift, n bits lsb first, back to idle
   task automatic scan(input logic ir, input logic [63:0] din, input int n,
                       output logic [63:0] dout);
      logic b;
      dout = '0;
      step(1'b1, 1'b1, b);
      if (ir) step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
      step(1'b0, 1'b1, b);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], b);
         dout[i] = b;
      end
      step(1'b1, 1'b1, b);
      step(1'b0, 1'b1, b);
   endtask
endmodule

/* verification/tb_top.sv */
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ns
module tb_top
   import bscan_pkg::*;
;
   localparam logic [31:0] IDV = 32'h1234_5671; // arbitrary value
   localparam logic [31:0] UCODE = 32'h0000_5A3C;
   logic core_clk, resetn, jtag_en, tck, tms, tdi, tdo_pin, tdo_out, tdo_oe_n, isp_write;
   logic u_tck, u_tms, u_tdi, u_tdo, u_data, u_oe_n;
   logic tdo_last = 1'b0;
   logic [7:0] core_out, pin_in, pin_out, core_in;
   logic [15:0] isp_wdata, isp_rdata;
   logic [3:0] instr;
   logic [63:0] q;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   int isp_pulses = 0;
   assign tdo_pin = tdo_oe_n ? ~tdo_last : tdo_out;
   bscan_port #(.IDCODE_VALUE(IDV), .USERCODE_VALUE(UCODE)) i_bscan_port (
      .CORE_CLK(core_clk), .RESETN(resetn), .JTAG_ENABLE(jtag_en), .TCK(tck), .TMS(tms),
      .TDI(tdi), .TDO_IN(tdo_pin), .TDO_OUT(tdo_out), .TDO_OE_N(tdo_oe_n), .USER_TCK(u_tck),
      .USER_TMS(u_tms), .USER_TDI(u_tdi), .USER_TDO(u_tdo), .USER_TDO_DATA(u_data),
      .USER_TDO_OE_N(u_oe_n), .CORE_OUT(core_out), .PIN_IN(pin_in), .PIN_OUT(pin_out),
      .CORE_IN(core_in), .ISP_WRITE(isp_write), .ISP_WDATA(isp_wdata),
      .ISP_RDATA(isp_rdata), .INSTR(instr));
   tap_master i_tap_master (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (!tdo_oe_n) tdo_last <= tdo_out;
      if (isp_write === 1'b1) isp_pulses++;
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         summarize();
      end
   end
   task automatic summarize();
      if (err_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic ir(input logic [3:0] op);
      @(posedge core_clk) #1;
      i_tap_master.scan(1'b1, {60'h0, op}, 4, q);
      chk("ir capture", {60'h0, IR_CAPTURE}, q);
      chk("instruction", {60'h0, op}, instr);
   endtask
   task automatic dr(input logic [63:0] d, input int n);
      @(posedge core_clk) #1;
      i_tap_master.scan(1'b0, d, n, q);
   endtask
   task automatic t_id();
      chk("reset instruction", {60'h0, OP_IDCODE}, instr);
      @(posedge core_clk) #1;
      i_tap_master.tap_reset();
      dr(64'h0, 32);
      chk("idcode", {32'h0, IDV}, q);
      ir(OP_USERCODE);
      dr(64'h0, 32);
      chk("usercode", {32'h0, UCODE}, q);
   endtask
   task automatic t_bsr();
      @(posedge core_clk) #1 pin_in = 8'hA5;
      ir(OP_SAMPLE);
      dr(64'h3C, 8);
      chk("sampled pins", 64'hA5, q);
      chk("pins in use", {56'h0, core_out}, pin_out);
      ir(OP_EXTEST);
      chk("preloaded pins", 64'h3C, pin_out);
      @(posedge core_clk) #1 pin_in = 8'h96;
      dr(64'hC3, 8);
      chk("captured inputs", 64'h96, q);
      chk("driven outputs", 64'hC3, pin_out);
   endtask
   task automatic t_byp();
      logic [3:0] ops [4] = '{OP_BYPASS, 4'h7, 4'hE, OP_CLAMP};
      foreach (ops[i]) begin
         ir(ops[i]);
         dr(64'h1B2, 9);
         chk("bypass path", 64'h164, q);
      end
      chk("clamped pins", 64'hC3, pin_out);
   endtask
   task automatic t_isp();
      @(posedge core_clk) #1 isp_rdata = 16'h6E1D;
      ir(OP_ISP_WRITE);
      isp_pulses = 0;
      dr(64'hBEEF, 16);
      chk("write pulses", 64'h1, isp_pulses);
      chk("write word", 64'hBEEF, isp_wdata);
      ir(OP_ISP_READ);
      dr(64'h0, 16);
      chk("read word", 64'h6E1D, q);
   endtask
   task automatic t_user();
      logic b;
      ir(OP_BYPASS);
      i_tap_master.tap_reset();
      chk("tap reset instruction", {60'h0, OP_IDCODE}, instr);
      ir(OP_BYPASS);
      @(posedge core_clk) #1 jtag_en = 1'b0;
      u_oe_n = 1'b0;
      u_data = 1'b1;
      i_tap_master.step(1'b1, 1'b0, b);
      repeat (3) @(posedge core_clk);
      #1;
      chk("user pins", 64'h5, {u_tck, u_tms, u_tdi, u_tdo});
      chk("user tdo drive", 64'h2, {tdo_out, tdo_oe_n});
      @(posedge core_clk) #1 u_oe_n = 1'b1;
      jtag_en = 1'b1;
      repeat (4) @(posedge core_clk);
      chk("instruction after user mode", {60'h0, OP_IDCODE}, instr);
   endtask
   initial begin
      resetn = 1'b0;
      jtag_en = 1'b1;
      u_data = 1'b0;
      u_oe_n = 1'b1;
      core_out = 8'h5A;
      pin_in = 8'h00;
      isp_rdata = 16'h0000;
      repeat (12) @(posedge core_clk);
      #1 resetn = 1'b1;
      repeat (3) @(posedge core_clk);
      t_id();
      t_bsr();
      t_byp();
      t_isp();
      t_user();
      summarize();
   end
endmodule
